// ==== rtl/fidr_regs.vh ====
// constants for the flash id and parameter read-back command slice
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`ifndef FIDR_REGS_VH
`define FIDR_REGS_VH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define FIDR_OP_READ_PARAM 8'h61
`define FIDR_OP_EXT_PARAM 8'h81
`define FIDR_OP_CLEAR_ERR 8'h82
`define FIDR_OP_LEGACY_ID 8'hab
`define FIDR_OP_STD_ID 8'h9f
`define FIDR_OP_STD_ID_QUAD 8'haf
`define FIDR_OP_MAKER_DEV 8'h90
`define FIDR_OP_UNIQUE 8'h4b
`define FIDR_OP_TABLE 8'h5a
`define FIDR_OP_NOP 8'h00
`define FIDR_OP_RESET_ARM 8'h66
`define FIDR_OP_RESET 8'h99

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FIDR_RP_DUMMY_HI 6
`define FIDR_RP_DUMMY_LO 3
`define FIDR_RP_BURST_HI 2
`define FIDR_RP_BURST_LO 0
`define FIDR_XP_PROT_BIT 4
`define FIDR_XP_PROG_BIT 3
`define FIDR_XP_ERASE_BIT 2

// ----------------------------------------------------------------
// counts, reset values and lane enable patterns
// ----------------------------------------------------------------
`define FIDR_ADDR_BYTES 2'd3
`define FIDR_DUMMY_DEFAULT 4'd8
`define FIDR_TABLE_DUMMY 4'd8
`define FIDR_UID_BYTES 5'd16
`define FIDR_FLAGS_RESET 3'b000
`define FIDR_OE_N_IDLE 4'hf
`define FIDR_OE_N_SPI 4'hd
`define FIDR_OE_N_QPI 4'h0

`endif

// ==== rtl/fidr_sync.v ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module fidr_sync #(
  parameter WIDTH = 6,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_stable
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  integer k;

  // s1 feeds only s2; a bit counts once s2 and s3 agree
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      o_stable <= RESET_VAL;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      for (k = 0; k < WIDTH; k = k + 1) begin
        if (s2[k] == s3[k]) begin
          o_stable[k] <= s3[k];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/fidr_rom.v ====
// unique number and parameter table byte lookup
`timescale 1ns/1ps
`default_nettype none
module fidr_rom #(
  // unique number value is arbitrary
  parameter [127:0] UNIQUE_NUM = 128'h0123456789abcdeffedcba9876543210
) (
  input wire i_uid_sel,
  input wire [7:0] i_addr,
  output wire [7:0] o_byte
);
  function [7:0] table_byte;
    input [7:0] a;
    begin
      // small header only; anything outside it reads as ff,
      // which a host must not rely on
      case (a)
        8'h00: table_byte = 8'h53;
        8'h01: table_byte = 8'h46;
        8'h02: table_byte = 8'h44;
        8'h03: table_byte = 8'h50;
        8'h04: table_byte = 8'h06;
        8'h05: table_byte = 8'h01;
        8'h06: table_byte = 8'h00;
        8'h07: table_byte = 8'hff;
        default: table_byte = 8'hff;
      endcase
    end
  endfunction

  function [7:0] uid_byte;
    input [3:0] a;
    begin
      uid_byte = UNIQUE_NUM[8'd127 - {a, 3'b000} -: 8];
    end
  endfunction

  assign o_byte = i_uid_sel ? uid_byte(i_addr[3:0]) : table_byte(i_addr);
endmodule
`default_nettype wire

// ==== rtl/fidr_core.v ====
// command decoder for id reads, parameter read-back and error clear
`timescale 1ns/1ps
`default_nettype none
`include "fidr_regs.vh"
module fidr_core #(
  // identity codes below are arbitrary
  parameter [7:0] MAKER_CODE = 8'hc5,
  parameter [7:0] DEVICE_CODE = 8'h21,
  parameter [15:0] TYPE_CAP = 16'h4321,
  parameter [127:0] UNIQUE_NUM = 128'h0123456789abcdeffedcba9876543210
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_sck,
  input wire i_cs_n,
  input wire [3:0] i_io,
  input wire i_qpi_mode,
  input wire i_write_in_progress,
  input wire [7:0] i_read_param,
  input wire [7:0] i_ext_param,
  input wire i_prot_err_set,
  input wire i_prog_err_set,
  input wire i_erase_err_set,
  output reg [3:0] o_io,
  output reg [3:0] o_io_oe_n,
  output reg [2:0] o_error_flags,
  output reg [3:0] o_dummy_cycle_bits,
  output reg [2:0] o_burst_bits,
  output reg o_wake,
  output reg o_reset_armed,
  output reg o_reset_fire
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] ST_OPC = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_DUMMY = 3'd2;
  localparam [2:0] ST_DATA = 3'd3;
  localparam [2:0] ST_DONE = 3'd4;

  // ----------------------------------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------------------------------
  wire [5:0] pins;
  wire cs_n_f;
  wire sck_f;
  wire [3:0] io_f;
  reg sck_q;
  reg cs_q;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;

  fidr_sync #(
    .WIDTH(6),
    .RESET_VAL(6'h20)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async({i_cs_n, i_sck, i_io}),
    .o_stable(pins)
  );

  assign cs_n_f = pins[5];
  assign sck_f = pins[4];
  assign io_f = pins[3:0];
  assign sck_rise = sck_f & ~sck_q & ~cs_n_f;
  assign sck_fall = ~sck_f & sck_q & ~cs_n_f;
  assign cs_rise = cs_n_f & ~cs_q;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // zero in the dummy field selects the default count
  function [3:0] dummy_need;
    input [3:0] field;
    begin
      if (field == 4'd0) begin
        dummy_need = `FIDR_DUMMY_DEFAULT;
      end else begin
        dummy_need = field;
      end
    end
  endfunction

  // bits moved per clock: one in spi, four in qpi
  function [3:0] lane_step;
    input qpi;
    begin
      lane_step = qpi ? 4'd4 : 4'd1;
    end
  endfunction

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  reg [2:0] state;
  reg [7:0] cmd;
  reg opc_done;
  reg [7:0] sh_in;
  reg [2:0] nbits;
  reg [1:0] acnt;
  reg [23:0] addr;
  reg [3:0] dcnt;
  reg [2:0] opos;
  reg [7:0] bidx;
  reg [1:0] trip;
  reg [7:0] hold;

  wire [3:0] step;
  wire [3:0] in_sum;
  wire in_byte_done;
  wire [7:0] in_byte;
  wire [3:0] out_sum;
  wire out_byte_done;

  assign step = lane_step(i_qpi_mode);
  assign in_sum = {1'b0, nbits} + step;
  assign in_byte_done = in_sum[3];
  assign in_byte = i_qpi_mode ? {sh_in[3:0], io_f} : {sh_in[6:0], io_f[0]};
  assign out_sum = {1'b0, opos} + step;
  assign out_byte_done = out_sum[3];

  // ----------------------------------------------------------------
  // data source
  // ----------------------------------------------------------------
  wire [7:0] rom_byte;
  wire uid_sel;
  wire [7:0] rom_addr;
  wire [7:0] ext_rb;
  reg [7:0] src;
  wire [7:0] cur;

  assign uid_sel = (cmd == `FIDR_OP_UNIQUE);
  // unique number wraps inside sixteen bytes
  assign rom_addr = uid_sel ? {4'h0, addr[3:0] + bidx[3:0]} :
                              addr[7:0] + bidx;

  fidr_rom #(
    .UNIQUE_NUM(UNIQUE_NUM)
  ) u_rom (
    .i_uid_sel(uid_sel),
    .i_addr(rom_addr),
    .o_byte(rom_byte)
  );

  // extended read-back: live error flags over the volatile copy
  assign ext_rb = {i_ext_param[7:5],
                   o_error_flags[2],
                   o_error_flags[1],
                   o_error_flags[0],
                   i_ext_param[1:0]};

  always @* begin
    case (cmd)
      `FIDR_OP_READ_PARAM: src = i_read_param;
      `FIDR_OP_EXT_PARAM: src = ext_rb;
      `FIDR_OP_LEGACY_ID: src = DEVICE_CODE;
      `FIDR_OP_STD_ID,
      `FIDR_OP_STD_ID_QUAD: begin
        // three-byte loop
        case (trip)
          2'd0: src = MAKER_CODE;
          2'd1: src = TYPE_CAP[15:8];
          default: src = TYPE_CAP[7:0];
        endcase
      end
      `FIDR_OP_MAKER_DEV: begin
        // address bit0 picks the first byte
        src = (bidx[0] ^ addr[0]) ? DEVICE_CODE : MAKER_CODE;
      end
      `FIDR_OP_UNIQUE,
      `FIDR_OP_TABLE: src = rom_byte;
      default: src = 8'hff;
    endcase
  end

  assign cur = (opos == 3'd0) ? src : hold;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      state <= ST_OPC;
      cmd <= 8'h00;
      opc_done <= 1'b0;
      sh_in <= 8'h00;
      nbits <= 3'd0;
      acnt <= 2'd0;
      addr <= 24'h000000;
      dcnt <= 4'd0;
      opos <= 3'd0;
      bidx <= 8'h00;
      trip <= 2'd0;
      hold <= 8'h00;
      o_io <= 4'h0;
      o_io_oe_n <= `FIDR_OE_N_IDLE;
    end else begin
      sck_q <= sck_f;
      cs_q <= cs_n_f;
      if (cs_n_f) begin
        // deselect ends any frame and frees the lines
        state <= ST_OPC;
        nbits <= 3'd0;
        acnt <= 2'd0;
        opos <= 3'd0;
        bidx <= 8'h00;
        trip <= 2'd0;
        o_io_oe_n <= `FIDR_OE_N_IDLE;
        if (cs_rise) begin
          opc_done <= 1'b0;
        end
      end else if (sck_rise) begin
        sh_in <= in_byte;
        nbits <= in_sum[2:0];
        case (state)
          ST_OPC: begin
            if (in_byte_done) begin
              cmd <= in_byte;
              opc_done <= 1'b1;
              case (in_byte)
                `FIDR_OP_READ_PARAM,
                `FIDR_OP_EXT_PARAM: state <= ST_DATA;
                `FIDR_OP_LEGACY_ID: begin
                  // ignored during a write cycle
                  state <= i_write_in_progress ? ST_DONE : ST_ADDR;
                end
                `FIDR_OP_STD_ID: begin
                  state <= i_qpi_mode ? ST_DONE : ST_DATA;
                end
                `FIDR_OP_STD_ID_QUAD: begin
                  state <= i_qpi_mode ? ST_DATA : ST_DONE;
                end
                `FIDR_OP_MAKER_DEV,
                `FIDR_OP_UNIQUE,
                `FIDR_OP_TABLE: state <= ST_ADDR;
                default: state <= ST_DONE;
              endcase
            end
          end
          ST_ADDR: begin
            // legacy id dummies and maker/device dummies are taken
            // like address bytes
            if (in_byte_done) begin
              addr <= {addr[15:0], in_byte};
              acnt <= acnt + 2'd1;
              if (acnt == `FIDR_ADDR_BYTES - 2'd1) begin
                case (cmd)
                  `FIDR_OP_UNIQUE: begin
                    // same framing in both lane modes
                    dcnt <= dummy_need(
                      i_read_param[`FIDR_RP_DUMMY_HI:`FIDR_RP_DUMMY_LO]);
                    state <= ST_DUMMY;
                  end
                  `FIDR_OP_TABLE: begin
                    dcnt <= `FIDR_TABLE_DUMMY;
                    state <= ST_DUMMY;
                  end
                  default: state <= ST_DATA;
                endcase
              end
            end
          end
          ST_DUMMY: begin
            dcnt <= dcnt - 4'd1;
            if (dcnt == 4'd1) begin
              state <= ST_DATA;
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end else if (sck_fall && state == ST_DATA) begin
        // msb first, launched on the falling clock edge
        if (opos == 3'd0) begin
          hold <= src;
        end
        if (i_qpi_mode) begin
          o_io <= (opos == 3'd0) ? cur[7:4] : cur[3:0];
          o_io_oe_n <= `FIDR_OE_N_QPI;
        end else begin
          o_io <= {2'b00, cur[3'd7 - opos], 1'b0};
          o_io_oe_n <= `FIDR_OE_N_SPI;
        end
        opos <= out_sum[2:0];
        if (out_byte_done) begin
          bidx <= bidx + 8'd1;
          trip <= (trip == 2'd2) ? 2'd0 : trip + 2'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // end-of-frame actions, sticky flags and parameter field copies
  // ----------------------------------------------------------------
  // actions wait for deselect so a half-sent opcode never acts
  wire frame_end;
  wire clr_flags;
  wire [2:0] set_flags;

  assign frame_end = cs_rise & opc_done;
  assign clr_flags = frame_end & (cmd == `FIDR_OP_CLEAR_ERR);
  assign set_flags = {i_prot_err_set, i_prog_err_set, i_erase_err_set};

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_error_flags <= `FIDR_FLAGS_RESET;
      o_wake <= 1'b0;
      o_reset_armed <= 1'b0;
      o_reset_fire <= 1'b0;
      o_dummy_cycle_bits <= 4'd0;
      o_burst_bits <= 3'd0;
    end else begin
      o_dummy_cycle_bits <=
        i_read_param[`FIDR_RP_DUMMY_HI:`FIDR_RP_DUMMY_LO];
      o_burst_bits <= i_read_param[`FIDR_RP_BURST_HI:`FIDR_RP_BURST_LO];
      // a set in the clear cycle wins
      o_error_flags <= (o_error_flags & ~{3{clr_flags}}) | set_flags;
      o_wake <= 1'b0;
      o_reset_fire <= 1'b0;
      if (frame_end) begin
        case (cmd)
          `FIDR_OP_RESET_ARM: o_reset_armed <= 1'b1;
          `FIDR_OP_RESET: begin
            o_reset_fire <= o_reset_armed;
            o_reset_armed <= 1'b0;
          end
          `FIDR_OP_LEGACY_ID: begin
            o_wake <= ~i_write_in_progress;
            o_reset_armed <= 1'b0;
          end
          // nop and every other command drop the arm
          default: o_reset_armed <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/fidr_assertions.sv ====
// assertions on the id and parameter read-back command slice
`timescale 1ns/1ps
`default_nettype none
module fidr_assertions (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_qpi_mode,
  input wire logic i_write_in_progress,
  input wire logic [7:0] i_read_param,
  input wire logic i_erase_err_set,
  input wire logic [3:0] o_io_oe_n,
  input wire logic [2:0] o_error_flags,
  input wire logic [3:0] o_dummy_cycle_bits,
  input wire logic [2:0] o_burst_bits,
  input wire logic o_wake,
  input wire logic o_reset_armed,
  input wire logic o_reset_fire
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // ----
  // properties
  // ----
  // eight clocks leave room for the pin filter before lines must go quiet
  sequence cs_idle_s;
    i_cs_n [*8];
  endsequence
  sequence frame_end_s;
    i_cs_n && !$past(i_write_in_progress);
  endsequence
  oe_idle_a: assert property (cs_idle_s |-> o_io_oe_n == 4'hf)
    else $error("outputs driven while deselected");
  oe_spi_a: assert property (
    !i_qpi_mode |-> o_io_oe_n inside {4'hf, 4'hd})
    else $error("wrong lane enable in single lane mode");
  oe_qpi_a: assert property (
    i_qpi_mode |-> o_io_oe_n inside {4'hf, 4'h0})
    else $error("wrong lane enable in four lane mode");
  flag_clear_a: assert property (
    |($past(o_error_flags) & ~o_error_flags) |-> i_cs_n)
    else $error("error flag dropped inside a frame");
  flag_set_a: assert property (
    i_erase_err_set |-> ##[1:2] o_error_flags[0])
    else $error("erase flag not set");
  wake_cause_a: assert property (o_wake |-> frame_end_s)
    else $error("wake outside frame end or during write");
  wake_pulse_a: assert property (o_wake |=> !o_wake)
    else $error("wake longer than one cycle");
  fire_cause_a: assert property (
    o_reset_fire |-> $past(o_reset_armed) ##1 !o_reset_fire)
    else $error("reset fired without arm");
  arm_at_end_a: assert property ($rose(o_reset_armed) |-> i_cs_n)
    else $error("reset armed inside a frame");
  field_copy_a: assert property ($stable(i_read_param) |=>
    {o_dummy_cycle_bits, o_burst_bits} == $past(i_read_param[6:0]))
    else $error("parameter fields not copied");
endmodule
`default_nettype wire

// ==== testbench/fidr_host.sv ====
// host side serial flash controller model, one or four lanes, mode 0
`timescale 1ns/1ps
`default_nettype none
module fidr_host (
  output logic o_sck,
  output logic o_cs_n,
  output logic [3:0] o_io,
  input wire logic [3:0] i_io
);
  // ----
  // frame tasks
  // ----
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end
  // clock stands low outside frames; select gaps exceed the 200 ns minimum
  task automatic sel(input logic on);
    #200;
    o_cs_n = ~on;
    #200;
  endtask
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_io[0] = b[i];
      #100 o_sck = 1'b1;
      #100 o_sck = 1'b0;
    end
  endtask
  // released data lines keep moving so a stale value never passes
  task automatic get(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_io = ~o_io;
      #100 o_sck = 1'b1;
      #95 b[i] = i_io[1];
      #5 o_sck = 1'b0;
    end
  endtask
  // four lane variants: high nibble first, one nibble per clock
  task automatic put_q(input logic [7:0] b);
    for (int i = 1; i >= 0; i--) begin
      o_io = b[4*i +: 4];
      #100 o_sck = 1'b1;
      #100 o_sck = 1'b0;
    end
  endtask
  task automatic get_q(output logic [7:0] b);
    for (int i = 1; i >= 0; i--) begin
      o_io = ~o_io;
      #100 o_sck = 1'b1;
      #95 b[4*i +: 4] = i_io;
      #5 o_sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/flash_id_param_readback_bench.sv ====
// self-checking bench for the id and parameter read-back slice
`timescale 1ns/1ps
`default_nettype none
module flash_id_param_readback_bench;
  logic clk, nrst, qpi, write_in_progress;
  logic [2:0] eset;
  logic [7:0] rp, xp, b, u0, u1;
  wire logic sck, cs_n, wake, armed, fire;
  wire logic [3:0] hio, dio, oe_n, dummy;
  // a released lane shows the inverse of its last value, so stale data fails
  wire logic [3:0] line = dio ^ oe_n;
  wire logic [2:0] flags, burst;
  int bad_count, cmp_count, wakes, fires;
  logic [7:0] tbl [8] = '{8'h53, 8'h46, 8'h44, 8'h50,
                          8'h06, 8'h01, 8'h00, 8'hff};
  fidr_host fidr_host_inst (.o_sck(sck), .o_cs_n(cs_n), .o_io(hio),
    .i_io(line));
  fidr_core fidr_core_inst (.i_core_clk(clk), .i_nrst(nrst), .i_sck(sck),
    .i_cs_n(cs_n), .i_io(hio), .i_qpi_mode(qpi),
    .i_write_in_progress(write_in_progress), .i_read_param(rp), .i_ext_param(xp),
    .i_prot_err_set(eset[2]), .i_prog_err_set(eset[1]),
    .i_erase_err_set(eset[0]), .o_io(dio), .o_io_oe_n(oe_n),
    .o_error_flags(flags), .o_dummy_cycle_bits(dummy), .o_burst_bits(burst),
    .o_wake(wake), .o_reset_armed(armed), .o_reset_fire(fire));
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic snd(input logic [7:0] v);
    if (qpi) fidr_host_inst.put_q(v);
    else fidr_host_inst.put(v);
  endtask
  task automatic op(input logic [7:0] c, input int pre);
    fidr_host_inst.sel(1'b1);
    snd(c);
    repeat (pre) snd(8'h00);
  endtask
  task automatic rd(input string what, input logic [7:0] exp);
    if (qpi) fidr_host_inst.get_q(b);
    else fidr_host_inst.get(b);
    chk(what, b, exp);
  endtask
  task automatic fin(input string name);
    fidr_host_inst.sel(1'b0);
    repeat (8) @(negedge clk);
    $display("test %s done", name);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----
  // clock, pulse counters, watchdog
  // ----
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wake === 1'b1) wakes++;
    if (fire === 1'b1) fires++;
  end
  // run needs about 155 us; 2 ms leaves generous slack
  initial begin
    #2_000_000;
    bad_count++;
    test_done;
  end
  // ----
  // tests
  // ----
  initial begin
    nrst = 1'b0;
    qpi = 1'b0;
    write_in_progress = 1'b0;
    eset = 3'b000;
    rp = 8'ha5;
    xp = 8'ha1;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    chk("dummy bits", {4'h0, dummy}, 8'h04);
    chk("burst bits", {5'h00, burst}, 8'h05);
    op(8'h61, 0);
    rd("read param", 8'ha5);
    rd("read param again", 8'ha5);
    fin("read param");
    eset = 3'b111;
    @(negedge clk);
    eset = 3'b000;
    repeat (6) @(negedge clk);
    chk("flags set", {5'h00, flags}, 8'h07);
    op(8'h81, 0);
    rd("ext param flags", 8'hbd);
    fin("ext param");
    chk("flags sticky", {5'h00, flags}, 8'h07);
    op(8'h82, 0);
    fin("clear flags");
    chk("flags cleared", {5'h00, flags}, 8'h00);
    op(8'h81, 0);
    rd("ext param clear", 8'ha1);
    fin("ext param clear");
    op(8'hab, 3);
    rd("legacy id", 8'h21);
    rd("legacy id repeat", 8'h21);
    fin("legacy id");
    chk("wake count", wakes[7:0], 8'h01);
    write_in_progress = 1'b1;
    op(8'hab, 0);
    fin("legacy id in write");
    write_in_progress = 1'b0;
    chk("wake blocked", wakes[7:0], 8'h01);
    op(8'haf, 0);
    fidr_host_inst.get(b);
    chk("quad id refused", {4'h0, oe_n}, 8'h0f);
    fin("quad id in single lane");
    op(8'h9f, 0);
    rd("std id maker", 8'hc5);
    rd("std id type hi", 8'h43);
    rd("std id type lo", 8'h21);
    rd("std id loop", 8'hc5);
    fin("std id");
    for (int a = 0; a < 2; a++) begin
      op(8'h90, 2);
      fidr_host_inst.put(a[7:0]);
      rd("maker dev first", a ? 8'h21 : 8'hc5);
      rd("maker dev second", a ? 8'hc5 : 8'h21);
      rd("maker dev third", a ? 8'h21 : 8'hc5);
      fin("maker dev");
    end
    rp = 8'h00;
    op(8'h4b, 4);
    fidr_host_inst.get(u0);
    fidr_host_inst.get(u1);
    repeat (14) fidr_host_inst.get(b);
    rd("unique wrap 0", u0);
    rd("unique wrap 1", u1);
    chk("unique first", u0, 8'h01);
    fin("unique number");
    op(8'h5a, 4);
    for (int i = 0; i < 8; i++) begin
      rd("table", tbl[i]);
    end
    fin("param table");
    op(8'h66, 0);
    fin("arm");
    chk("armed", {7'h00, armed}, 8'h01);
    op(8'h00, 0);
    fin("nop");
    chk("nop disarms", {7'h00, armed}, 8'h00);
    op(8'h66, 0);
    fin("arm again");
    op(8'h99, 0);
    fin("reset");
    chk("reset fired", fires[7:0], 8'h01);
    rp = 8'h33;
    qpi = 1'b1;
    repeat (4) @(negedge clk);
    chk("dummy bits qpi", {4'h0, dummy}, 8'h06);
    chk("burst bits qpi", {5'h00, burst}, 8'h03);
    op(8'h61, 0);
    rd("qpi read param", 8'h33);
    fin("qpi read param");
    op(8'haf, 0);
    rd("qpi id maker", 8'hc5);
    rd("qpi id type hi", 8'h43);
    rd("qpi id type lo", 8'h21);
    rd("qpi id loop", 8'hc5);
    fin("qpi std id");
    op(8'h9f, 0);
    fidr_host_inst.get_q(b);
    chk("single id refused", {4'h0, oe_n}, 8'h0f);
    fin("single id in qpi");
    op(8'h4b, 6);
    rd("qpi unique 0", 8'h01);
    rd("qpi unique 1", 8'h23);
    fin("qpi unique number");
    op(8'h5a, 7);
    rd("qpi table 0", 8'h53);
    rd("qpi table 1", 8'h46);
    fin("qpi param table");
    test_done;
  end
endmodule
bind fidr_core fidr_assertions fidr_assertions_inst (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_cs_n(i_cs_n),
  .i_qpi_mode(i_qpi_mode), .i_write_in_progress(i_write_in_progress),
  .i_read_param(i_read_param), .i_erase_err_set(i_erase_err_set),
  .o_io_oe_n(o_io_oe_n), .o_error_flags(o_error_flags),
  .o_dummy_cycle_bits(o_dummy_cycle_bits), .o_burst_bits(o_burst_bits),
  .o_wake(o_wake), .o_reset_armed(o_reset_armed),
  .o_reset_fire(o_reset_fire));
`default_nettype wire
